// >>> imp_irq_mask_power_ctrl.sv
// interrupt enable masking and power/reset control register
// Functional notes
// - Bit 7 gates the high-voltage supply flag onto the interrupt pin and resets to 0.
// - Bit 8 gates the PGA overvoltage flag onto the interrupt pin and resets to 0.
// - Bit 6 gates the secondary high-voltage supply flag and resets to 0.
// - Bit 4 gates the thermal warning flag and resets to 0.
// - Bits 3 and 2 gate the overcurrent and configuration error flags, each from 0.
// - Bit 1 gates the CRC error flag and resets to 0.
// - Bit 0 gates the input edge flag and resets to 0.
// - Enable register bits 23 to 9 and bit 5 read as zero and ignore writes.
// - Power control bits 23, 21, 19, 17 are writable from 0; all others read zero.
// - The DAC power-down bit at 0 keeps the DAC running and at 1 powers it down.
module imp_irq_mask_power_ctrl
  import imp_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          clkEn,
  input  wire imp_reg_req_t  regReq,
  input  wire imp_flags_t    flags,
  output logic [23:0]        regRdata,
  output logic               regRvalid,
  output logic               intPin_n,
  output logic               dacPowerDown,
  output logic               dacSoftReset,
  output logic               globalPowerDown,
  output logic               globalSoftReset
);

  // ----------------------------------------------------------------
  // flag placement
  // ----------------------------------------------------------------
  // lays each flag at the bit position of its enable
  function automatic logic [23:0] placeFlags(input imp_flags_t f);
    logic [23:0] v;
    v                  = 24'h000000;
    v[POS_PGA_OVV]     = f.pgaOvervoltage;
    v[POS_HV_SUPPLY]   = f.hvSupply;
    v[POS_HV_SECOND]   = f.hvSupplySecondary;
    v[POS_THERMAL]     = f.thermalWarning;
    v[POS_OVERCURRENT] = f.overcurrent;
    v[POS_CONFIG_ERR]  = f.configError;
    v[POS_CRC_ERR]     = f.crcError;
    v[POS_INPUT_EDGE]  = f.inputEdge;
    return v;
  endfunction

  logic [23:0] intEnable;
  logic [23:0] powerCtrl;
  logic [23:0] next_intEnable;
  logic [23:0] next_powerCtrl;
  logic [23:0] next_regRdata;
  logic        next_regRvalid;
  logic        next_intPin_n;
  logic [23:0] flagVec;
  logic [23:0] maskedVec;

  // ----------------------------------------------------------------
  // masking
  // ----------------------------------------------------------------
  // flags arrive from same-clock logic, so no synchroniser is needed
  assign flagVec   = placeFlags(flags);
  // per-source gating of enables 0..8
  assign maskedVec = flagVec & intEnable;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // reserved bits never take a write, so they stay at reset zero
  always_comb
  begin
    next_intEnable = intEnable;
    next_powerCtrl = powerCtrl;
    next_regRdata  = regRdata;
    next_regRvalid = 1'b0;
    if (regReq.wr && regReq.addr == ADDR_INT_ENABLE)
    begin
      next_intEnable = regReq.wdata & INT_ENABLE_WMASK;
    end
    if (regReq.wr && regReq.addr == ADDR_POWER_CTRL)
    begin
      next_powerCtrl = regReq.wdata & POWER_CTRL_WMASK;
    end
    if (regReq.rd)
    begin
      next_regRvalid = 1'b1;
      case (regReq.addr)
        ADDR_INT_ENABLE: next_regRdata = intEnable;
        ADDR_POWER_CTRL: next_regRdata = powerCtrl;
        default:         next_regRdata = 24'h000000; // unmapped reads zero
      endcase
    end
    // pin low while any enabled flag is set
    next_intPin_n = ~(|maskedVec);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // clock enable low freezes every flop, pin included
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intEnable       <= INT_ENABLE_RST;
      powerCtrl       <= POWER_CTRL_RST;
      regRdata        <= 24'h000000;
      regRvalid       <= 1'b0;
      intPin_n        <= 1'b1;
      dacPowerDown    <= 1'b0;
      dacSoftReset    <= 1'b0;
      globalPowerDown <= 1'b0;
      globalSoftReset <= 1'b0;
    end
    else if (clkEn)
    begin
      intEnable       <= next_intEnable;
      powerCtrl       <= next_powerCtrl;
      regRdata        <= next_regRdata;
      regRvalid       <= next_regRvalid;
      intPin_n        <= next_intPin_n;
      // outputs take the control bits from next_powerCtrl, on the same edge as the register
      dacPowerDown    <= next_powerCtrl[POS_DAC_PD];
      dacSoftReset    <= next_powerCtrl[POS_DAC_RST];
      globalPowerDown <= next_powerCtrl[POS_GLOBAL_PD];
      globalSoftReset <= next_powerCtrl[POS_GLOBAL_RST];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence sWrEnable;
    clkEn && regReq.wr && regReq.addr == ADDR_INT_ENABLE;
  endsequence

  sequence sWrPower;
    clkEn && regReq.wr && regReq.addr == ADDR_POWER_CTRL;
  endsequence

  sequence sRdEnable;
    clkEn && regReq.rd && !regReq.wr && regReq.addr == ADDR_INT_ENABLE;
  endsequence

  sequence sRdPower;
    clkEn && regReq.rd && !regReq.wr && regReq.addr == ADDR_POWER_CTRL;
  endsequence

  AST_HV_SUPPLY: assert property (
    @(posedge clock) disable iff (!rst_n)
    clkEn && (flagVec == 24'h000080) |=> (intPin_n == !$past(intEnable[7])))
    else $error("hv supply gating wrong");

  AST_PGA_OVV: assert property (
    @(posedge clock) disable iff (!rst_n)
    clkEn && (flagVec == 24'h000100) |=> (intPin_n == !$past(intEnable[8])))
    else $error("pga overvoltage gating wrong");

  AST_HV_SECOND: assert property (
    @(posedge clock) disable iff (!rst_n)
    clkEn && (flagVec == 24'h000040) |=> (intPin_n == !$past(intEnable[6])))
    else $error("secondary hv gating wrong");

  AST_THERMAL: assert property (
    @(posedge clock) disable iff (!rst_n)
    clkEn && flags.thermalWarning && intEnable[4] |=> !intPin_n)
    else $error("thermal warning not reaching pin");

  AST_OVC_CONFIG: assert property (
    @(posedge clock) disable iff (!rst_n)
    clkEn && (flagVec == 24'h00000c) && (intEnable[3:2] == 2'b00)
    |=> intPin_n)
    else $error("overcurrent or config flag leaked");

  AST_CRC: assert property (
    @(posedge clock) disable iff (!rst_n)
    clkEn && (flagVec == 24'h000002) |=> (intPin_n == !$past(intEnable[1])))
    else $error("crc gating wrong");

  AST_EDGE: assert property (
    @(posedge clock) disable iff (!rst_n)
    clkEn && (flagVec == 24'h000001) |=> (intPin_n == !$past(intEnable[0])))
    else $error("input edge gating wrong");

  AST_RESERVED: assert property (
    @(posedge clock) disable iff (!rst_n)
    sWrEnable ##2 sRdEnable |=> regRvalid && (regRdata[23:9] == 15'h0000)
    && !regRdata[5])
    else $error("reserved enable bits not zero");

  AST_POWER_WR: assert property (
    @(posedge clock) disable iff (!rst_n)
    sWrPower |=> (powerCtrl == ($past(regReq.wdata) & 24'haa0000))
    && (globalSoftReset == $past(regReq.wdata[17])))
    else $error("power control write wrong");

  AST_DAC_PD: assert property (
    @(posedge clock) disable iff (!rst_n)
    sWrPower ##1 (clkEn && !regReq.wr)
    |=> dacPowerDown == $past(regReq.wdata[23], 2))
    else $error("dac power down not following");

  // read of the enable register answers the stored value one cycle later
  AST_READ_ENABLE: assert property (
    @(posedge clock) disable iff (!rst_n)
    sRdEnable |=> regRvalid && (regRdata == $past(intEnable)))
    else $error("enable read answer wrong");

  AST_POWER_RESERVED: assert property (
    @(posedge clock) disable iff (!rst_n)
    sWrPower ##2 sRdPower |=> regRvalid
    && ((regRdata & ~POWER_CTRL_WMASK) == 24'h000000))
    else $error("reserved power bits not zero");

  // frozen flops must not move, or a gated host would miss a pin change
  AST_FREEZE: assert property (
    @(posedge clock) disable iff (!rst_n)
    !clkEn |=> $stable(intPin_n) && $stable(intEnable) && $stable(powerCtrl))
    else $error("state moved while clock enable low");

  AST_PIN: assert property (
    @(posedge clock) disable iff (!rst_n)
    clkEn |=> intPin_n == ($past(flagVec & intEnable) == 24'h000000))
    else $error("interrupt pin not matching masked flags");

endmodule

// >>> imp_pkg.sv
// shared constants and carriers for the interrupt mask and power control block
package imp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int            REG_W            = 24;
  localparam int            ADDR_W           = 7;
  localparam logic [6:0]    ADDR_INT_ENABLE  = 7'h08;
  localparam logic [6:0]    ADDR_POWER_CTRL  = 7'h09;

  // ----------------------------------------------------------------
  // interrupt enable fields
  // ----------------------------------------------------------------
  localparam int            POS_PGA_OVV      = 8;
  localparam int            POS_HV_SUPPLY    = 7;
  localparam int            POS_HV_SECOND    = 6;
  localparam int            POS_THERMAL      = 4;
  localparam int            POS_OVERCURRENT  = 3;
  localparam int            POS_CONFIG_ERR   = 2;
  localparam int            POS_CRC_ERR      = 1;
  localparam int            POS_INPUT_EDGE   = 0;
  localparam logic [23:0]   INT_ENABLE_WMASK = 24'h0001df;
  localparam logic [23:0]   INT_ENABLE_RST   = 24'h000000;

  // ----------------------------------------------------------------
  // power control fields
  // ----------------------------------------------------------------
  localparam int            POS_DAC_PD       = 23;
  localparam int            POS_DAC_RST      = 21;
  localparam int            POS_GLOBAL_PD    = 19;
  localparam int            POS_GLOBAL_RST   = 17;
  localparam logic [23:0]   POWER_CTRL_WMASK = 24'haa0000;
  localparam logic [23:0]   POWER_CTRL_RST   = 24'h000000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [6:0]        addr;
    logic [23:0]       wdata;
  } imp_reg_req_t;

  typedef struct packed {
    logic              pgaOvervoltage;
    logic              hvSupply;
    logic              hvSupplySecondary;
    logic              thermalWarning;
    logic              overcurrent;
    logic              configError;
    logic              crcError;
    logic              inputEdge;
  } imp_flags_t;

endpackage

// >>> imp_host_model.sv
// host-side model that watches the interrupt pin and counts its events
module imp_host_model
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic intPin_n,
  output int        irqCount
);
  timeunit 1ns;
  timeprecision 1ps;

  logic lastPin;

  // edge-triggered host: a level held low is counted once, not per cycle
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastPin  <= 1'b1;
      irqCount <= 0;
    end
    else
    begin
      lastPin <= intPin_n;
      if (lastPin && !intPin_n)
        irqCount <= irqCount + 1;
    end
  end
endmodule

// >>> test_irq_mask_and_power_ctrl.sv
// self-checking bench for the interrupt mask and power control block
module test_irq_mask_and_power_ctrl import imp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clock;
  logic         rst_n;
  logic         clkEn;
  imp_reg_req_t regReq;
  imp_flags_t   flags;
  logic [23:0]  regRdata;
  logic         regRvalid;
  logic         intPin_n;
  logic [3:0]   pwr;
  logic [23:0]  v;
  int           irqCount;
  int           miscompares;
  int           cmp_count;
  int           pos;

  imp_irq_mask_power_ctrl i_dut (.clock(clock), .rst_n(rst_n),
    .clkEn(clkEn), .regReq(regReq), .flags(flags), .regRdata(regRdata),
    .regRvalid(regRvalid), .intPin_n(intPin_n), .dacPowerDown(pwr[3]),
    .dacSoftReset(pwr[2]), .globalPowerDown(pwr[1]),
    .globalSoftReset(pwr[0]));

  imp_host_model i_host (.clock(clock), .rst_n(rst_n),
    .intPin_n(intPin_n), .irqCount(irqCount));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] e,
                     input logic [23:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(posedge clock) regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock) regReq <= '0;
  endtask

  // answer lands on the taking edge itself; bounded wait anyway
  task automatic rd(input logic [6:0] a, output logic [23:0] d);
    int n;
    @(posedge clock) regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h0};
    @(posedge clock) regReq <= '0;
    #1;
    for (n = 0; n < 4 && regRvalid !== 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    if (n == 4)
    begin
      miscompares++;
      $display("CHECK FAILED regRvalid expected 1 seen 0");
      wrap_up();
    end
    else
    begin
      d = regRdata;
    end
  endtask

  // flags are levels; the pin follows one registered stage later
  task automatic setf(input imp_flags_t f);
    @(posedge clock) flags <= f;
    repeat (2) @(posedge clock);
    #1;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    regReq = '0;
    flags = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    chk("intPin_n", 24'h1, {23'h0, intPin_n});
    rd(ADDR_INT_ENABLE, v);
    chk("enable rst", 24'h0, v);
    rd(ADDR_POWER_CTRL, v);
    chk("power rst", 24'h0, v);
    chk("power pins", 24'h0, {20'h0, pwr});
    rd(7'h0a, v);
    chk("unmapped", 24'h0, v);
    $display("test reset values done");
    // all ones, then reserved bits only: only the enables survive
    wr(ADDR_INT_ENABLE, 24'hffffff);
    rd(ADDR_INT_ENABLE, v);
    chk("enable mask", 24'h0001df, v);
    wr(ADDR_INT_ENABLE, 24'hfffe20);
    rd(ADDR_INT_ENABLE, v);
    chk("reserved", 24'h0, v);
    $display("test reserved bits done");
    // each source: blocked with every other enable on, then let through
    for (int i = 0; i < 8; i++)
    begin
      pos = (i > 4) ? i + 1 : i;
      wr(ADDR_INT_ENABLE, 24'h0001df & ~(24'h1 << pos));
      setf(imp_flags_t'(8'h1 << i));
      chk("masked", 24'h1, {23'h0, intPin_n});
      wr(ADDR_INT_ENABLE, 24'h1 << pos);
      setf(imp_flags_t'(8'h1 << i));
      chk("enabled", 24'h0, {23'h0, intPin_n});
      setf('0);
      chk("released", 24'h1, {23'h0, intPin_n});
    end
    chk("host count", 24'h8, 24'(irqCount));
    $display("test per-source masking done");
    wr(ADDR_POWER_CTRL, 24'hffffff);
    rd(ADDR_POWER_CTRL, v);
    chk("power mask", 24'haa0000, v);
    chk("power pins", 24'hf, {20'h0, pwr});
    wr(ADDR_POWER_CTRL, 24'h800000);
    rd(ADDR_POWER_CTRL, v);
    chk("dac pd", 24'h8, {20'h0, pwr});
    $display("test power control done");
    // a write while the clock enable is low must leave state alone
    @(posedge clock) clkEn <= 1'b0;
    wr(ADDR_POWER_CTRL, 24'h0);
    @(posedge clock) clkEn <= 1'b1;
    rd(ADDR_POWER_CTRL, v);
    chk("frozen", 24'h800000, v);
    $display("test clock enable done");
    wrap_up();
  end
endmodule
